// *** core/vitals_monitor.sv ***
// Output sync control, vitals monitor and serial register port
`include "vitals_defines.svh"

module vitals_monitor (
  // Clock and reset
  input  logic                clk_sys,
  input  logic                reset_n,
  input  logic                clk_en,
  // Serial control port
  input  logic                scl_in,
  input  logic                sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  // Output synchronization
  input  logic                sync_input_pin,
  input  logic                soft_pin_mode,
  input  logic                slow_clk_in,
  output vitals_pkg::div_ctrl_t div_ctrl,
  // Device vitals
  input  logic [15:0]         vital_in,
  input  logic [1:0]          slip_toggle,
  output logic                monitor_pin_zero,
  output logic                monitor_pin_one,
  output logic                vitals_irq,
  // Analog configuration
  output logic [7:0]          signal_loss_config,
  output logic [7:0]          status_slew_control,
  // Power-up load and EEPROM
  input  logic                control_source_select,
  input  logic                ee_commit_req,
  output logic                load_start,
  output logic                load_from_eeprom,
  output logic                ee_commit
);
  import vitals_pkg::*;

  // --------------------------------------------------------
  // State
  // --------------------------------------------------------
  typedef struct packed {
    async_in_t         s1;
    async_in_t         s2;
    logic              scl_d;
    logic              sda_d;
    logic              slow_d;
    logic [1:0]        slip_d;
    i2c_st_t           st;
    logic [2:0]        bit_cnt;
    logic              full;
    logic [7:0]        shreg;
    logic [7:0]        ptr;
    logic              rw;
    logic              sda_oe;
    logic              sda_out;
    logic [12:0][7:0]  regs;
    logic [1:0]        applied;
    logic [1:0]        fall_cnt;
    logic [1:0]        dly_cnt;
    logic [1:0][3:0]   slip_cnt;
    logic [1:0]        lock_loss;
    logic              irq;
    logic              pin0;
    logic              pin1;
    logic [1:0]        boot;
    logic              load_start;
    logic              from_ee;
    logic              ee_commit;
    logic [6:0]        ee_cnt;
    div_ctrl_t         div;
  } state_t;

  state_t q_reg;
  state_t q_next;

  // --------------------------------------------------------
  // Functions
  // --------------------------------------------------------
  function automatic logic [4:0] reg_index(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    unique case (a)
      `OFF_SYNC:   r = {1'b1, `IDX_SYNC};
      `OFF_RT:     r = {1'b1, `IDX_RT};
      `OFF_MASK:   r = {1'b1, `IDX_MASK};
      `OFF_POL:    r = {1'b1, `IDX_POL};
      `OFF_LAT:    r = {1'b1, `IDX_LAT};
      `OFF_ICTL:   r = {1'b1, `IDX_ICTL};
      `OFF_MUTE:   r = {1'b1, `IDX_MUTE};
      `OFF_LOSCFG: r = {1'b1, `IDX_LOSCFG};
      `OFF_SELA:   r = {1'b1, `IDX_SELA};
      `OFF_SELB:   r = {1'b1, `IDX_SELB};
      `OFF_SLEW:   r = {1'b1, `IDX_SLEW};
      `OFF_P1SYNC: r = {1'b1, `IDX_P1SYNC};
      `OFF_P2SYNC: r = {1'b1, `IDX_P2SYNC};
      default:     r = 5'h00;
    endcase
    return r;
  endfunction : reg_index

  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
    logic [4:0] r;
    r = reg_index(a);
    return r[4] ? s.regs[r[3:0]] : 8'h00;
  endfunction : reg_read

  function automatic logic status_level(input logic [15:0] v, input logic [3:0] sel,
                                        input logic pol, input logic mute_en,
                                        input logic lol_src);
    logic l;
    l = v[sel] ^ pol;
    if (mute_en && lol_src) begin
      l = pol;
    end
    return l;
  endfunction : status_level

  // --------------------------------------------------------
  // Next state
  // --------------------------------------------------------
  always_comb begin
    logic        scl;
    logic        sda;
    logic        start;
    logic        stop;
    logic        rise;
    logic        fall;
    logic [4:0]  wi;
    logic [1:0]  rd_clr;
    logic [15:0] v;
    logic [7:0]  src;
    logic [7:0]  rt_base;
    logic [7:0]  lat_base;
    logic [7:0]  ictl;
    logic        sync_n;
    logic [1:0]  target;
    logic        slow_fall;
    q_next = q_reg;
    scl = q_reg.s2.pins.scl;
    sda = q_reg.s2.pins.sda;
    wi = 5'h00;
    rd_clr = 2'b00;
    q_next.s1 = {{scl_in, sda_in, sync_input_pin, soft_pin_mode, slow_clk_in,
                  control_source_select}, vital_in, slip_toggle};
    q_next.s2 = q_reg.s1;
    q_next.scl_d = scl;
    q_next.sda_d = sda;
    start = scl && q_reg.scl_d && q_reg.sda_d && !sda;
    stop = scl && q_reg.scl_d && !q_reg.sda_d && sda;
    rise = scl && !q_reg.scl_d;
    fall = !scl && q_reg.scl_d;

    // ------------------------------------------------------
    // Serial register port, one byte per register
    // ------------------------------------------------------
    if (stop) begin
      q_next.st = S_IDLE;
      q_next.sda_oe = 1'b0;
    end else if (start) begin
      q_next.st = S_ADDR;
      q_next.bit_cnt = 3'h0;
      q_next.full = 1'b0;
      q_next.sda_oe = 1'b0;
    end else begin
      unique case (q_reg.st)
        S_IDLE: begin
        end
        S_ADDR, S_PTR, S_WDATA: begin
          if (rise) begin
            q_next.shreg = {q_reg.shreg[6:0], sda};
            q_next.bit_cnt = q_reg.bit_cnt + 3'h1;
            q_next.full = (q_reg.bit_cnt == 3'h7);
          end else if (fall && q_reg.full) begin
            q_next.full = 1'b0;
            q_next.sda_oe = 1'b1;
            if (q_reg.st == S_ADDR) begin
              if (q_reg.shreg[7:1] == `SLAVE_ADDR) begin
                q_next.rw = q_reg.shreg[0];
                q_next.st = S_A_ACK;
              end else begin
                q_next.sda_oe = 1'b0;
                q_next.st = S_IDLE;
              end
            end else if (q_reg.st == S_PTR) begin
              q_next.ptr = q_reg.shreg;
              q_next.st = S_W_ACK;
            end else begin
              wi = reg_index(q_reg.ptr);
              if (wi[4] && wi[3:0] != `IDX_RT && wi[3:0] != `IDX_LAT) begin
                q_next.regs[wi[3:0]] = q_reg.shreg;
              end
              q_next.ptr = q_reg.ptr + 8'h01;
              q_next.st = S_W_ACK;
            end
          end
        end
        S_A_ACK: begin
          if (fall) begin
            q_next.bit_cnt = 3'h0;
            if (q_reg.rw) begin
              q_next.shreg = reg_read(q_reg, q_reg.ptr);
              q_next.sda_oe = !q_next.shreg[7];
              q_next.st = S_RDATA;
            end else begin
              q_next.sda_oe = 1'b0;
              q_next.st = S_PTR;
            end
          end
        end
        S_W_ACK: begin
          if (fall) begin
            q_next.sda_oe = 1'b0;
            q_next.bit_cnt = 3'h0;
            q_next.st = S_WDATA;
          end
        end
        S_RDATA: begin
          if (fall) begin
            if (q_reg.bit_cnt == 3'h7) begin
              q_next.sda_oe = 1'b0;
              q_next.st = S_R_ACK;
              wi = reg_index(q_reg.ptr);
              rd_clr[0] = wi[4] && (wi[3:0] == `IDX_RT);
              rd_clr[1] = wi[4] && (wi[3:0] == `IDX_LAT);
              q_next.ptr = q_reg.ptr + 8'h01;
            end else begin
              q_next.shreg = {q_reg.shreg[6:0], 1'b0};
              q_next.sda_oe = !q_reg.shreg[6];
              q_next.bit_cnt = q_reg.bit_cnt + 3'h1;
            end
          end
        end
        S_R_ACK: begin
          if (rise && sda) begin
            q_next.st = S_IDLE;
          end else if (fall) begin
            q_next.bit_cnt = 3'h0;
            q_next.shreg = reg_read(q_reg, q_reg.ptr);
            q_next.sda_oe = !q_next.shreg[7];
            q_next.st = S_RDATA;
          end
        end
      endcase
    end

    // ------------------------------------------------------
    // Lock detectors
    // ------------------------------------------------------
    v = q_reg.s2.vitals;
    q_next.slip_d = q_reg.s2.slips;
    for (int k = 0; k < 2; k++) begin
      if (v[`V_CAL1 + k]) begin
        q_next.lock_loss[k] = 1'b0;
        q_next.slip_cnt[k] = 4'h0;
      end else if (q_reg.s2.slips[k] ^ q_reg.slip_d[k]) begin
        if (q_reg.slip_cnt[k] == `SLIP_LIMIT) begin
          q_next.lock_loss[k] = 1'b1;
          q_next.slip_cnt[k] = 4'h0;
        end else begin
          q_next.slip_cnt[k] = q_reg.slip_cnt[k] + 4'h1;
        end
      end
    end
    v[`V_LOL1] = q_reg.lock_loss[0];
    v[`V_LOL2] = q_reg.lock_loss[1];
    v[`V_IRQ] = q_reg.irq;

    // ------------------------------------------------------
    // Interrupt flags; a new event wins over a read clear
    // ------------------------------------------------------
    src = {v[`V_SW2], v[`V_SW1], v[`V_CAL1 + 1], v[`V_CAL1],
           q_reg.lock_loss[1], q_reg.lock_loss[0], v[`V_LOS_SEC], v[`V_LOS_PRI]};
    ictl = q_reg.regs[`IDX_ICTL];
    rt_base = rd_clr[0] ? 8'h00 : q_reg.regs[`IDX_RT];
    lat_base = rd_clr[1] ? 8'h00 : q_reg.regs[`IDX_LAT];
    q_next.regs[`IDX_RT] = rt_base | src;
    q_next.regs[`IDX_LAT] = lat_base | (ictl[`IRQ_EN_BIT] ? src : 8'h00);
    if (!ictl[`IRQ_EN_BIT]) begin
      q_next.irq = 1'b0;
    end else if (ictl[`IRQ_AND_BIT]) begin
      q_next.irq = &(q_reg.regs[`IDX_LAT] | q_reg.regs[`IDX_MASK]);
    end else begin
      q_next.irq = |(q_reg.regs[`IDX_LAT] & ~q_reg.regs[`IDX_MASK]);
    end

    // ------------------------------------------------------
    // Status pins
    // ------------------------------------------------------
    q_next.pin0 = status_level(v, q_reg.regs[`IDX_SELA][3:0], q_reg.regs[`IDX_POL][0],
                               q_reg.regs[`IDX_MUTE][0],
                               q_reg.lock_loss[q_reg.regs[`IDX_MUTE][`MUTE_SRC0]]);
    q_next.pin1 = status_level(v, q_reg.regs[`IDX_SELB][3:0], q_reg.regs[`IDX_POL][1],
                               q_reg.regs[`IDX_MUTE][1],
                               q_reg.lock_loss[q_reg.regs[`IDX_MUTE][`MUTE_SRC1]]);

    // ------------------------------------------------------
    // Output synchronization
    // ------------------------------------------------------
    sync_n = q_reg.regs[`IDX_SYNC][`SYNC_BIT] &
             (q_reg.s2.pins.soft_mode ? q_reg.s2.pins.sync_pin : 1'b1);
    target = {q_reg.regs[`IDX_P2SYNC][`PSYNC_BIT], q_reg.regs[`IDX_P1SYNC][`PSYNC_BIT]} &
             {2{!sync_n}};
    q_next.slow_d = q_reg.s2.pins.slow_clk;
    slow_fall = q_reg.slow_d && !q_reg.s2.pins.slow_clk;
    if (target == q_reg.applied) begin
      q_next.fall_cnt = 2'h0;
      q_next.dly_cnt = 2'h0;
    end else if (q_reg.fall_cnt != `SYNC_FALLS) begin
      if (slow_fall) begin
        q_next.fall_cnt = q_reg.fall_cnt + 2'h1;
      end
    end else if (q_reg.dly_cnt != `VCO_DLY) begin
      q_next.dly_cnt = q_reg.dly_cnt + 2'h1;
    end else begin
      q_next.applied = target;
      q_next.fall_cnt = 2'h0;
      q_next.dly_cnt = 2'h0;
    end
    q_next.div.mute = q_next.applied;
    q_next.div.reset_n = ~q_next.applied;

    // ------------------------------------------------------
    // Power-up load and EEPROM rewrite limit
    // ------------------------------------------------------
    q_next.load_start = 1'b0;
    if (q_reg.boot == `BOOT_WAIT) begin
      q_next.from_ee = q_reg.s2.pins.css;
      q_next.load_start = 1'b1;
      q_next.boot = `BOOT_DONE;
    end else if (q_reg.boot != `BOOT_DONE) begin
      q_next.boot = q_reg.boot + 2'h1;
    end
    q_next.ee_commit = ee_commit_req && (q_reg.ee_cnt != `EE_WRITE_MAX);
    if (q_next.ee_commit) begin
      q_next.ee_cnt = q_reg.ee_cnt + 7'h01;
    end
  end

  // --------------------------------------------------------
  // Registers
  // --------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q_reg <= '0;
      q_reg.regs[`IDX_SYNC] <= `SYNC_RST;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  // --------------------------------------------------------
  // Outputs
  // --------------------------------------------------------
  assign sda_out = q_reg.sda_out;
  assign sda_oe = q_reg.sda_oe;
  assign div_ctrl = q_reg.div;
  assign monitor_pin_zero = q_reg.pin0;
  assign monitor_pin_one = q_reg.pin1;
  assign vitals_irq = q_reg.irq;
  assign signal_loss_config = q_reg.regs[`IDX_LOSCFG];
  assign status_slew_control = q_reg.regs[`IDX_SLEW];
  assign load_start = q_reg.load_start;
  assign load_from_eeprom = q_reg.from_ee;
  assign ee_commit = q_reg.ee_commit;
endmodule : vitals_monitor

// *** core/vitals_defines.svh ***
// Register offsets, field positions, reset values and counts
`ifndef VITALS_DEFINES_SVH
`define VITALS_DEFINES_SVH
`define SLAVE_ADDR   7'h54
`define OFF_SYNC     8'h0C
`define OFF_RT       8'h0D
`define OFF_MASK     8'h0E
`define OFF_POL      8'h0F
`define OFF_LAT      8'h10
`define OFF_ICTL     8'h11
`define OFF_MUTE     8'h17
`define OFF_LOSCFG   8'h19
`define OFF_SELA     8'h1B
`define OFF_SELB     8'h1C
`define OFF_SLEW     8'h31
`define OFF_P1SYNC   8'h38
`define OFF_P2SYNC   8'h47
`define IDX_SYNC     4'h0
`define IDX_RT       4'h1
`define IDX_MASK     4'h2
`define IDX_POL      4'h3
`define IDX_LAT      4'h4
`define IDX_ICTL     4'h5
`define IDX_MUTE     4'h6
`define IDX_LOSCFG   4'h7
`define IDX_SELA     4'h8
`define IDX_SELB     4'h9
`define IDX_SLEW     4'hA
`define IDX_P1SYNC   4'hB
`define IDX_P2SYNC   4'hC
`define SYNC_BIT     6
`define PSYNC_BIT    1
`define IRQ_EN_BIT   0
`define IRQ_AND_BIT  1
`define MUTE_SRC0    2
`define MUTE_SRC1    3
`define V_LOS_PRI    0
`define V_LOS_SEC    1
`define V_LOL1       2
`define V_LOL2       5
`define V_CAL1       8
`define V_IRQ        10
`define V_SW1        14
`define V_SW2        15
`define SYNC_RST     8'h40
`define SYNC_FALLS   2'h2
`define VCO_DLY      2'h2
`define SLIP_LIMIT   4'h7
`define EE_WRITE_MAX 7'h64
`define BOOT_WAIT    2'h2
`define BOOT_DONE    2'h3
`endif

// *** core/vitals_pkg.sv ***
// Types shared by the vitals monitor
package vitals_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
    logic sync_pin;
    logic soft_mode;
    logic slow_clk;
    logic css;
  } pin_in_t;

  typedef struct packed {
    pin_in_t     pins;
    logic [15:0] vitals;
    logic [1:0]  slips;
  } async_in_t;

  typedef struct packed {
    logic [1:0] mute;
    logic [1:0] reset_n;
  } div_ctrl_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_A_ACK = 3'b010,
    S_PTR   = 3'b011,
    S_WDATA = 3'b100,
    S_W_ACK = 3'b101,
    S_RDATA = 3'b110,
    S_R_ACK = 3'b111
  } i2c_st_t;
endpackage : vitals_pkg

// *** testbench/vitals_monitor_assertions.sv ***
// Port-level assertions for the vitals monitor
module vitals_monitor_checker (
  // Clock and reset
  input logic                  clk_sys,
  input logic                  reset_n,
  // Watched ports
  input logic                  scl_in,
  input logic                  sda_out,
  input logic                  sda_oe,
  input logic                  slow_clk_in,
  input vitals_pkg::div_ctrl_t div_ctrl,
  input logic                  ee_commit_req,
  input logic                  ee_commit,
  input logic                  load_start,
  input logic [7:0]            signal_loss_config,
  input logic [7:0]            status_slew_control
);
  timeunit 1ns;
  timeprecision 1ns;
  import vitals_pkg::*;
  logic       slow_prev;
  logic [3:0] fall_age;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Cycles since the last falling edge of the slow clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slow_prev <= 1'b0;
      fall_age  <= 4'hF;
    end else begin
      slow_prev <= slow_clk_in;
      if (slow_prev && !slow_clk_in) fall_age <= 4'h0;
      else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
    end
  end

  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  a_mute_with_reset: assert property ((div_ctrl.mute & div_ctrl.reset_n) == 2'b00)
    else $error("driver muted while divider runs");
  a_div_on_fall: assert property (($changed(div_ctrl) && $past(div_ctrl) != 4'h0) |-> fall_age <= 4'h9)
    else $error("divider control changed away from slow clock fall");
  a_grant_has_cause: assert property (ee_commit |-> $past(ee_commit_req))
    else $error("rewrite grant without request");
  a_load_once: assert property (load_start |=> !load_start [*8])
    else $error("load pulse repeated");
  a_load_after_reset: assert property ($rose(reset_n) |-> ##[1:4] load_start)
    else $error("no load pulse after reset");
  a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data line pulled while clock high");
  a_ack_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data line released while clock high");
  a_loss_by_write: assert property ($changed(signal_loss_config) |-> ##[0:6] sda_oe)
    else $error("loss config changed without write");
  a_slew_by_write: assert property ($changed(status_slew_control) |-> ##[0:6] sda_oe)
    else $error("slew control changed without write");
endmodule : vitals_monitor_checker

bind vitals_monitor vitals_monitor_checker vitals_monitor_checker_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .slow_clk_in(slow_clk_in), .div_ctrl(div_ctrl), .ee_commit_req(ee_commit_req), .ee_commit(ee_commit),
  .load_start(load_start), .signal_loss_config(signal_loss_config),
  .status_slew_control(status_slew_control));

// *** testbench/i2c_host_model.sv ***
// Serial control port host model
module i2c_host_model (
  // Clock
  input  logic clk_sys,
  // Bus lines
  input  logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QTR = 4;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : pause

  // Start or repeated start
  task automatic start_cond();
    sda_drv <= 1'b1;
    pause(QTR);
    scl <= 1'b1;
    pause(2 * QTR);
    sda_drv <= 1'b0;
    pause(2 * QTR);
    scl <= 1'b0;
  endtask : start_cond

  // Eight bits MSB first then the ninth acknowledge bit
  task automatic byte_io(input logic [7:0] wr, input logic host_ack, output logic [7:0] rd, output logic acked);
    logic [8:0] bits;
    bits = {wr, host_ack};
    for (int i = 8; i >= 0; i--) begin
      pause(QTR);
      sda_drv <= bits[i];
      pause(QTR);
      scl <= 1'b1;
      pause(2 * QTR);
      if (i > 0) rd[i-1] = sda_line;
      else acked = !sda_line;
      scl <= 1'b0;
    end
  endtask : byte_io

  task automatic stop_cond();
    pause(QTR);
    sda_drv <= 1'b0;
    pause(QTR);
    scl <= 1'b1;
    pause(2 * QTR);
    sda_drv <= 1'b1;
    pause(2 * QTR);
  endtask : stop_cond
endmodule : i2c_host_model

// *** testbench/vitals_monitor_test.sv ***
// Self-checking bench for the vitals monitor
`include "vitals_defines.svh"
module vitals_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  import vitals_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_t;
  logic        clk_sys, reset_n, sync_input_pin, soft_pin_mode, slow_clk_in, ee_commit_req;
  logic        clk_en, control_source_select;
  logic [15:0] vital_in;
  logic [1:0]  slip_toggle;
  logic        sda_out, sda_oe, scl, sda_drv, sda_line, ack, load_start, load_from_eeprom, ee_commit;
  logic        monitor_pin_zero, monitor_pin_one, vitals_irq;
  logic [7:0]  signal_loss_config, status_slew_control, rd;
  div_ctrl_t   div_ctrl;
  int          mismatches, checks, cycles, grants;
  row_t rows [14] = '{
    '{8'h0E, 8'h00, 8'h00}, '{8'h0F, 8'h00, 8'h00}, '{8'h11, 8'h01, 8'h01}, '{8'h17, 8'h01, 8'h01},
    '{8'h19, 8'hA5, 8'hA5}, '{8'h1B, 8'h03, 8'h03}, '{8'h1C, 8'h0A, 8'h0A}, '{8'h31, 8'h5A, 8'h5A},
    '{8'h38, 8'h02, 8'h02}, '{8'h47, 8'h02, 8'h02}, '{8'h0C, 8'h40, 8'h40}, '{8'h0D, 8'hFF, 8'h00},
    '{8'h10, 8'hFF, 8'h00}, '{8'h20, 8'h00, 8'h00}};

  assign sda_line = sda_drv & ~sda_oe;

  vitals_monitor vitals_monitor_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .sync_input_pin(sync_input_pin), .soft_pin_mode(soft_pin_mode),
    .slow_clk_in(slow_clk_in), .div_ctrl(div_ctrl), .vital_in(vital_in), .slip_toggle(slip_toggle),
    .monitor_pin_zero(monitor_pin_zero), .monitor_pin_one(monitor_pin_one), .vitals_irq(vitals_irq),
    .signal_loss_config(signal_loss_config), .status_slew_control(status_slew_control),
    .control_source_select(control_source_select), .ee_commit_req(ee_commit_req), .load_start(load_start),
    .load_from_eeprom(load_from_eeprom), .ee_commit(ee_commit));
  i2c_host_model host_i (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    host_i.start_cond();
    host_i.byte_io({`SLAVE_ADDR, 1'b0}, 1'b1, rd, ack);
    host_i.byte_io(addr, 1'b1, rd, ack);
    host_i.byte_io(data, 1'b1, rd, ack);
    check({7'h0, ack}, 8'h01);
    host_i.stop_cond();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr);
    host_i.start_cond();
    host_i.byte_io({`SLAVE_ADDR, 1'b0}, 1'b1, rd, ack);
    host_i.byte_io(addr, 1'b1, rd, ack);
    host_i.start_cond();
    host_i.byte_io({`SLAVE_ADDR, 1'b1}, 1'b1, rd, ack);
    host_i.byte_io(8'hFF, 1'b1, rd, ack);
    host_i.stop_cond();
  endtask : reg_read

  task automatic expect_read(input logic [7:0] addr, input logic [7:0] want);
    reg_read(addr);
    check(rd, want);
  endtask : expect_read

  task automatic wait_mute(input logic [1:0] want);
    for (int n = 0; n < 200 && div_ctrl.mute !== want; n++) tick(1);
    check({6'h0, div_ctrl.mute}, {6'h0, want});
    check({6'h0, div_ctrl.reset_n}, {6'h0, ~want});
  endtask : wait_mute

  task automatic vital_pulse(input int idx);
    vital_in[idx] <= 1'b1;
    tick(4);
    vital_in[idx] <= 1'b0;
    tick(6);
  endtask : vital_pulse

  task automatic test_done();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always begin
    tick(10);
    slow_clk_in <= ~slow_clk_in;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    {reset_n, sync_input_pin, soft_pin_mode, slow_clk_in, ee_commit_req, clk_en, control_source_select} = 7'b0100011;
    vital_in = 16'h0000;
    slip_toggle = 2'h0;
    tick(12);
    check({4'h0, div_ctrl}, 8'h00);
    reset_n <= 1'b1;
    tick(4);
    check({4'h0, div_ctrl}, 8'h03);
    check({7'h0, load_from_eeprom}, 8'h01);
    expect_read(8'h0C, 8'h40);
    expect_read(8'h0E, 8'h00);
    host_i.start_cond();
    host_i.byte_io({7'h55, 1'b0}, 1'b1, rd, ack);
    host_i.stop_cond();
    check({7'h0, ack}, 8'h00);
    foreach (rows[i]) begin
      reg_write(rows[i].addr, rows[i].wdata);
      expect_read(rows[i].addr, rows[i].rdata);
    end
    check(signal_loss_config, 8'hA5);
    check(status_slew_control, 8'h5A);
    // Output synchronization
    reg_write(8'h0C, 8'h00);
    wait_mute(2'b11);
    tick(100);
    reg_write(8'h47, 8'h00);
    wait_mute(2'b01);
    reg_write(8'h0C, 8'h40);
    wait_mute(2'b00);
    sync_input_pin <= 1'b0;
    tick(100);
    check({6'h0, div_ctrl.mute}, 8'h00);
    soft_pin_mode <= 1'b1;
    wait_mute(2'b01);
    tick(100);
    sync_input_pin <= 1'b1;
    wait_mute(2'b00);
    // Interrupts
    vital_pulse(0);
    check({7'h0, vitals_irq}, 8'h01);
    check({7'h0, monitor_pin_one}, 8'h01);
    expect_read(8'h0D, 8'h01);
    expect_read(8'h0D, 8'h00);
    expect_read(8'h10, 8'h01);
    tick(6);
    check({7'h0, vitals_irq}, 8'h00);
    reg_write(8'h0E, 8'h01);
    vital_pulse(0);
    check({7'h0, vitals_irq}, 8'h00);
    expect_read(8'h0D, 8'h01);
    reg_write(8'h0E, 8'hFC);
    reg_write(8'h11, 8'h03);
    vital_pulse(0);
    check({7'h0, vitals_irq}, 8'h00);
    vital_pulse(1);
    check({7'h0, vitals_irq}, 8'h01);
    reg_write(8'h11, 8'h00);
    reg_read(8'h10);
    vital_pulse(0);
    check({7'h0, vitals_irq}, 8'h00);
    expect_read(8'h10, 8'h00);
    // Status pins and lock loss
    vital_in[3] <= 1'b1;
    tick(6);
    check({7'h0, monitor_pin_zero}, 8'h01);
    reg_write(8'h0F, 8'h01);
    check({7'h0, monitor_pin_zero}, 8'h00);
    reg_write(8'h0F, 8'h00);
    repeat (7) begin
      slip_toggle[0] <= ~slip_toggle[0];
      tick(4);
    end
    tick(4);
    check({7'h0, monitor_pin_zero}, 8'h01);
    slip_toggle[0] <= ~slip_toggle[0];
    tick(8);
    check({7'h0, monitor_pin_zero}, 8'h00);
    reg_read(8'h0D);
    check({7'h0, rd[2]}, 8'h01);
    vital_pulse(8);
    check({7'h0, monitor_pin_zero}, 8'h01);
    // Clock enable low freezes all state
    reg_read(8'h0D);
    clk_en <= 1'b0;
    vital_pulse(1);
    clk_en <= 1'b1;
    expect_read(8'h0D, 8'h00);
    // EEPROM rewrite limit
    repeat (101) begin
      ee_commit_req <= 1'b1;
      tick(1);
      ee_commit_req <= 1'b0;
      @(negedge clk_sys);
      if (ee_commit === 1'b1) grants++;
      tick(1);
    end
    check(grants[7:0], 8'h64);
    // Reset in mid-run with the ROM as load source
    control_source_select <= 1'b0;
    reset_n <= 1'b0;
    tick(2);
    check({4'h0, div_ctrl}, 8'h00);
    reset_n <= 1'b1;
    tick(4);
    check({7'h0, load_from_eeprom}, 8'h00);
    check(signal_loss_config, 8'h00);
    expect_read(8'h0C, 8'h40);
    test_done();
  end
endmodule : vitals_monitor_test
